/* design/sam_bank.sv */
// Threefold register copy, one per privilege level
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_bank
  import sam_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // Access
  input  wire sam_pkg::sam_lvl_e   sel,
  input  wire logic                wr,
  input  wire logic [`SAM_DW-1:0]  wdata,
  output logic      [`SAM_DW-1:0]  rdata
);
  import sam_pkg::*;

  sam_bank_s s;
  sam_bank_s next_s;

  always_comb
  begin
    next_s = s;
    if (wr)
    begin
      case (sel)
        LVL_USER:  next_s.copy_user  = wdata;
        LVL_SYS:   next_s.copy_sys   = wdata;
        LVL_SUPER: next_s.copy_super = wdata;
        default:   next_s = s;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  always_comb
  begin
    case (sel)
      LVL_SYS:   rdata = s.copy_sys;
      LVL_SUPER: rdata = s.copy_super;
      default:   rdata = s.copy_user;
    endcase
  end

  copy_sep_a: assert property (@(posedge clock) disable iff (sys_rst)
    (wr && sel == LVL_USER) |=>
      $stable(s.copy_sys) && $stable(s.copy_super))
    else $error("user write reached another copy");

endmodule : sam_bank

/* design/sam_ctrl.sv */
// Register access gating and privilege mode control for the processor core
//
// Behaviour
// - Forbidden accesses ignored, reads return constant
// - Some registers held three times, per level
// - Non-peripheral register permissions fixed in hardware
// - Peripheral groups need granted right in user or in super contactless
// - Two mode bits select super, system, user
// - Vector call sets system flag
// - Vector call outside user raises exception
// - Every exception sets system flag
// - Interrupt entry sets flag per configured mode
// - Return restores mode status before event
// - User return needs user interrupts and active
// - System call to user entry enters user
// - Direct writes may only clear mode bits
// - System mode reaches every register
// - Full rights except contactless uses locked registers
// - After boot, only contactless sub-mode or test
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_ctrl
  import sam_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // Register access from the core
  input  wire sam_pkg::sam_bus_s       core_bus,
  output logic      [`SAM_DW-1:0]      rdata,
  // Core events
  input  wire sam_pkg::sam_ev_s        core_ev,
  output logic                         exception,
  output logic                         user_jump,
  // Rights from the memory management unit
  input  wire logic [`SAM_GROUPS-1:0]  mmu_user_rights,
  // Peripheral register bus
  output sam_pkg::sam_bus_s            periph_bus,
  input  wire logic [`SAM_DW-1:0]      periph_rdata,
  // Start-up control
  input  wire logic                    boot_done,
  input  wire logic                    test_lock_pin,
  // Mode and interrupt
  output sam_pkg::sam_mode_s           mode_status_register,
  output sam_pkg::sam_sub_e            sub_mode,
  output logic                         irq
);
  import sam_pkg::*;

  // ******************************************************************
  // State and decode
  // ******************************************************************
  sam_ctrl_s               s;
  sam_ctrl_s               next_s;
  sam_lvl_e                lvl;
  logic [`SAM_GROUPS-1:0]  rights;
  logic                    is_per;
  logic [3:0]              grp;
  logic                    wr_ok;
  logic                    rd_ok;
  logic                    bad_vcall;
  logic                    bad_return;
  logic                    raise;
  logic                    enter_user;
  logic                    ev_any;
  logic [`SAM_DW-1:0]      bank_rdata;
  logic                    bank_wr;
  logic [`SAM_IXW-1:0]     push_ix;
  logic [`SAM_IXW-1:0]     pop_ix;

  function automatic logic own_wr_ok(input logic [`SAM_AW-1:0] a,
                                     input sam_lvl_e l,
                                     input sam_sub_e sb);
    case (a)
      `SAM_A_MSR, `SAM_A_BANK:
        return 1'b1;
      `SAM_A_CFG, `SAM_A_IST, `SAM_A_IMSK:
        return l != LVL_USER;
      `SAM_A_CLR0, `SAM_A_CLR1:
        return l == LVL_SYS || (l == LVL_SUPER && sb != SUB_CL);
      default:
        return 1'b0;
    endcase
  endfunction : own_wr_ok

  function automatic logic own_mapped(input logic [`SAM_AW-1:0] a);
    return a <= `SAM_A_BANK;
  endfunction : own_mapped

  assign lvl    = sam_level(s.mode);
  assign is_per = core_bus.addr[`SAM_PER_HI:`SAM_PER_LO] == `SAM_PER_TAG;
  assign grp    = core_bus.addr[`SAM_GRP_HI:`SAM_GRP_LO];

  // full rights unless user, or super in contactless
  always_comb
  begin
    case (lvl)
      LVL_USER:  rights = mmu_user_rights;
      LVL_SUPER: rights = (s.sub == SUB_CL) ? s.cl_rights
                                            : `SAM_ALL_RIGHTS;
      default:   rights = `SAM_ALL_RIGHTS;
    endcase
  end

  assign wr_ok = is_per ? rights[grp]
                        : own_wr_ok(core_bus.addr, lvl, s.sub);
  assign rd_ok = is_per ? rights[grp] : own_mapped(core_bus.addr);

  assign bad_vcall  = core_ev.system_vector_call && lvl != LVL_USER;
  // user return needs user interrupts and one active
  assign bad_return = core_ev.return_from_interrupt && lvl == LVL_USER &&
                      !(s.irq_user && core_ev.irq_active);
  assign raise      = core_ev.exc_event || bad_vcall || bad_return;
  assign enter_user = core_ev.call_exec && lvl == LVL_SYS &&
                      core_ev.call_target == `SAM_USER_ENTRY;
  assign ev_any     = raise || core_ev.system_vector_call ||
                      core_ev.irq_entry || core_ev.return_from_interrupt ||
                      enter_user;

  // A full stack keeps overwriting its top slot rather than wrapping
  assign push_ix = (s.sp == `SAM_SPW'(`SAM_STK_DEPTH))
                 ? `SAM_IXW'(`SAM_STK_DEPTH - 1) : s.sp[`SAM_IXW-1:0];
  assign pop_ix  = `SAM_IXW'(s.sp - `SAM_SPW'(1));

  assign bank_wr = core_bus.wr && core_bus.addr == `SAM_A_BANK;

  sam_bank u_bank (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sel     (lvl),
    .wr      (bank_wr),
    .wdata   (core_bus.wdata),
    .rdata   (bank_rdata)
  );

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb
  begin
    next_s       = s;
    next_s.exc   = 1'b0;
    next_s.ujump = 1'b0;
    next_s.rdata = `SAM_ZERO_DATA;
    next_s.sync  = {s.sync[1:0], test_lock_pin};
    if (s.sync[1] == s.sync[2])
      next_s.lock = s.sync[2];

    // forbidden write has no effect, flagged only
    if (core_bus.wr && wr_ok && !is_per)
    begin
      case (core_bus.addr)
        // direct writes only clear mode bits
        `SAM_A_MSR:
          next_s.mode = s.mode & sam_mode_s'(core_bus.wdata[1:0]);
        `SAM_A_CFG:  next_s.irq_user = core_bus.wdata[0];
        `SAM_A_IST:  next_s.ist = s.ist & ~core_bus.wdata[`SAM_IST_W-1:0];
        `SAM_A_IMSK: next_s.imsk = core_bus.wdata[`SAM_IST_W-1:0];
        `SAM_A_CLR0: next_s.cl_rights[7:0] = core_bus.wdata;
        `SAM_A_CLR1: next_s.cl_rights[15:8] = core_bus.wdata;
        default:     next_s.mode = next_s.mode;
      endcase
    end
    if ((core_bus.wr && !wr_ok) || (core_bus.rd && !rd_ok))
      next_s.ist[`SAM_IST_DENY] = 1'b1;

    // forbidden read keeps zero, answered next cycle
    if (core_bus.rd && rd_ok)
    begin
      if (is_per)
        next_s.rdata = periph_rdata;
      else
      begin
        case (core_bus.addr)
          `SAM_A_MSR:  next_s.rdata = {6'h00, s.mode};
          `SAM_A_CFG:  next_s.rdata = {7'h00, s.irq_user};
          `SAM_A_IST:  next_s.rdata = {5'h00, s.ist};
          `SAM_A_IMSK: next_s.rdata = {5'h00, s.imsk};
          `SAM_A_CLR0: next_s.rdata = s.cl_rights[7:0];
          `SAM_A_CLR1: next_s.rdata = s.cl_rights[15:8];
          `SAM_A_BANK: next_s.rdata = bank_rdata;
          default:     next_s.rdata = `SAM_ZERO_DATA;
        endcase
      end
    end

    // Legal call, interrupt, user entry and non-empty legal return override a same-cycle mode write; an exception or fault only sets system_flag on it
    if (raise)
    begin
      next_s.stk[push_ix] = s.mode;
      next_s.sp           = (s.sp == `SAM_SPW'(`SAM_STK_DEPTH))
                          ? s.sp : s.sp + `SAM_SPW'(1);
      next_s.mode.system_flag = 1'b1;
      next_s.exc          = 1'b1;
      if (bad_vcall || bad_return)
        next_s.ist[`SAM_IST_FAULT] = 1'b1;
    end
    else if (core_ev.system_vector_call || core_ev.irq_entry)
    begin
      next_s.mode         = s.mode;
      next_s.stk[push_ix] = s.mode;
      next_s.sp           = (s.sp == `SAM_SPW'(`SAM_STK_DEPTH))
                          ? s.sp : s.sp + `SAM_SPW'(1);
      if (core_ev.system_vector_call || !s.irq_user)
        next_s.mode.system_flag = 1'b1;
    end
    else if (core_ev.return_from_interrupt)
    begin
      if (s.sp != `SAM_SPW'(0))
      begin
        next_s.mode = s.stk[pop_ix];
        next_s.sp   = s.sp - `SAM_SPW'(1);
      end
    end
    else if (enter_user)
    begin
      next_s.mode  = sam_mode_s'(2'h0);
      next_s.ujump = 1'b1;
      next_s.ist[`SAM_IST_UENT] = 1'b1;
    end

    // boot left for good, then test or contactless only
    case (s.sub)
      SUB_BOOT:
        if (boot_done)
        begin
          if (s.lock)
          begin
            next_s.sub  = SUB_CL;
            next_s.mode = sam_mode_s'(2'h1);
            next_s.sp   = `SAM_SPW'(0);
          end
          else
            next_s.sub = SUB_TEST;
        end
      SUB_TEST:
        if (s.lock)
          next_s.sub = SUB_CL;
      SUB_CL:
        next_s.sub = SUB_CL;
      default:
        next_s.sub = SUB_CL;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s      <= '0;
      s.mode <= sam_mode_s'(`SAM_RST_MODE);
      s.sub  <= SUB_BOOT;
      s.sync <= 3'h7;
      s.lock <= 1'b1;
    end
    else
      s <= next_s;
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  // mode bits decode the level
  assign mode_status_register = s.mode;
  assign sub_mode             = s.sub;
  assign rdata                = s.rdata;
  assign exception            = s.exc;
  assign user_jump            = s.ujump;
  assign irq                  = |(s.ist & s.imsk);

  // peripheral strobes pass only when permitted
  always_comb
  begin
    periph_bus       = core_bus;
    periph_bus.wr    = core_bus.wr && is_per && wr_ok;
    periph_bus.rd    = core_bus.rd && is_per && rd_ok;
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  deny_read_zero_a: assert property (
    core_bus.rd && !rd_ok |=> rdata == `SAM_ZERO_DATA)
    else $error("denied read returned data");
  deny_write_a: assert property (
    core_bus.wr && !wr_ok && core_bus.addr == `SAM_A_CFG
    |=> $stable(s.irq_user))
    else $error("denied write changed configuration");
  sys_full_rights_a: assert property (
    lvl == LVL_SYS |-> rights == `SAM_ALL_RIGHTS)
    else $error("system mode lacks full rights");
  user_rights_a: assert property (
    lvl == LVL_USER && is_per && !mmu_user_rights[grp]
    |-> !periph_bus.wr && !periph_bus.rd)
    else $error("ungranted peripheral access passed");
  vcall_sets_sys_a: assert property (
    core_ev.system_vector_call && lvl == LVL_USER
    |=> mode_status_register.system_flag)
    else $error("vector call did not enter system mode");
  vcall_fault_a: assert property (
    bad_vcall |=> exception && s.ist[`SAM_IST_FAULT])
    else $error("illegal vector call not trapped");
  exc_sets_sys_a: assert property (
    core_ev.exc_event |=> exception && mode_status_register.system_flag)
    else $error("exception left system flag clear");
  irq_user_keep_a: assert property (
    core_ev.irq_entry && !raise && !core_ev.system_vector_call &&
    s.irq_user && !boot_done |=> $stable(s.mode))
    else $error("user interrupt changed mode");
  ret_restore_a: assert property (
    (core_ev.system_vector_call && !raise && s.sp == `SAM_SPW'(0)) ##1
    (core_ev.return_from_interrupt && !raise && !boot_done)
    |=> s.mode == $past(s.mode, 2))
    else $error("return did not restore mode");
  ret_fault_a: assert property (
    bad_return |=> exception)
    else $error("illegal user return not trapped");
  user_entry_a: assert property (
    enter_user && !raise && !core_ev.system_vector_call &&
    !core_ev.irq_entry && !core_ev.return_from_interrupt
    |=> user_jump && s.mode == sam_mode_s'(2'h0) && $stable(s.sp))
    else $error("user entry call misbehaved");
  clear_only_a: assert property (
    core_bus.wr && core_bus.addr == `SAM_A_MSR && !ev_any && !boot_done
    |=> (s.mode & ~$past(s.mode)) == sam_mode_s'(2'h0))
    else $error("direct write raised a mode bit");
  boot_once_a: assert property (
    s.sub != SUB_BOOT |=> s.sub != SUB_BOOT)
    else $error("boot sub-mode re-entered");

  call_return_c: cover property (core_ev.system_vector_call &&
    lvl == LVL_USER ##[1:20] core_ev.return_from_interrupt);
  user_entry_c:  cover property (enter_user);
  denied_c:      cover property (core_bus.wr && !wr_ok);
  cl_mode_c:     cover property (s.sub == SUB_CL &&
                                 s.mode.super_system_flag);

endmodule : sam_ctrl

/* design/sam_defs.svh */
// Constants for the register access and privilege mode control block
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH

`define SAM_AW         8
`define SAM_DW         8
`define SAM_VAW        24
`define SAM_GROUPS     16
`define SAM_STK_DEPTH  4
`define SAM_SPW        3
`define SAM_IXW        2
`define SAM_IST_W      3

// Own register addresses
`define SAM_A_MSR      8'h00
`define SAM_A_CFG      8'h01
`define SAM_A_IST      8'h02
`define SAM_A_IMSK     8'h03
`define SAM_A_CLR0     8'h04
`define SAM_A_CLR1     8'h05
`define SAM_A_BANK     8'h06

// Peripheral window: address bits 7:6 equal 2'h2, group in bits 5:2
`define SAM_PER_TAG    2'h2
`define SAM_PER_HI     7
`define SAM_PER_LO     6
`define SAM_GRP_HI     5
`define SAM_GRP_LO     2

// Status bits
`define SAM_IST_DENY   0
`define SAM_IST_FAULT  1
`define SAM_IST_UENT   2

`define SAM_USER_ENTRY 24'h800000
`define SAM_ALL_RIGHTS 16'hffff
`define SAM_NO_RIGHTS  16'h0000
`define SAM_ZERO_DATA  8'h00
`define SAM_RST_MODE   2'h2

`endif

/* design/sam_pkg.sv */
// Types shared by the register access and privilege mode control block
package sam_pkg;
`include "sam_defs.svh"

  typedef struct packed {
    logic super_system_flag;
    logic system_flag;
  } sam_mode_s;

  typedef enum logic [1:0] {
    LVL_USER  = 2'b00,
    LVL_SYS   = 2'b01,
    LVL_SUPER = 2'b10
  } sam_lvl_e;

  typedef enum logic [1:0] {
    SUB_BOOT = 2'b00,
    SUB_TEST = 2'b01,
    SUB_CL   = 2'b10
  } sam_sub_e;

  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [`SAM_AW-1:0]   addr;
    logic [`SAM_DW-1:0]   wdata;
  } sam_bus_s;

  typedef struct packed {
    logic                 system_vector_call;
    logic                 exc_event;
    logic                 irq_entry;
    logic                 irq_active;
    logic                 return_from_interrupt;
    logic                 call_exec;
    logic [`SAM_VAW-1:0]  call_target;
  } sam_ev_s;

  typedef struct packed {
    logic [`SAM_DW-1:0]   copy_user;
    logic [`SAM_DW-1:0]   copy_sys;
    logic [`SAM_DW-1:0]   copy_super;
  } sam_bank_s;

  typedef struct packed {
    sam_mode_s                         mode;
    sam_sub_e                          sub;
    logic                              irq_user;
    logic [`SAM_IST_W-1:0]             ist;
    logic [`SAM_IST_W-1:0]             imsk;
    logic [`SAM_GROUPS-1:0]            cl_rights;
    sam_mode_s [`SAM_STK_DEPTH-1:0]    stk;
    logic [`SAM_SPW-1:0]               sp;
    logic [`SAM_DW-1:0]                rdata;
    logic                              exc;
    logic                              ujump;
    logic [2:0]                        sync;
    logic                              lock;
  } sam_ctrl_s;

  function automatic sam_lvl_e sam_level(input sam_mode_s m);
    if (m.super_system_flag)
      return LVL_SUPER;
    else if (m.system_flag)
      return LVL_SYS;
    else
      return LVL_USER;
  endfunction : sam_level

endpackage : sam_pkg

/* dv/sam_periph_model.sv */
// Peripheral register file standing on the gated peripheral bus
`timescale 1ns/1ps
`include "sam_defs.svh"
module sam_periph_model
  import sam_pkg::*;
(
  // Clock
  input  wire logic                clock,
  // Gated bus from the block
  input  wire sam_pkg::sam_bus_s   periph_bus,
  output logic      [`SAM_DW-1:0]  periph_rdata
);
  logic [`SAM_DW-1:0] mem [0:63];
  logic [`SAM_DW-1:0] churn;

  initial churn = 8'h00;

  always @(posedge clock)
  begin
    churn <= churn + 8'h3b;
    if (periph_bus.wr)
      mem[periph_bus.addr[5:0]] <= periph_bus.wdata;
  end

  // Unselected lines wander so a stale value never looks like a read
  assign periph_rdata = periph_bus.rd ? mem[periph_bus.addr[5:0]] : churn;
endmodule : sam_periph_model

/* dv/sfr_access_mode_control_test.sv */
// Self-checking bench for the register access and mode control block
`timescale 1ns/1ps
`include "sam_defs.svh"
module sfr_access_mode_control_test;
  import sam_pkg::*;
  localparam logic [4:0] VCALL = 5'h10;
  localparam logic [4:0] EXC  = 5'h08;
  localparam logic [4:0] IRQE = 5'h04;
  localparam logic [4:0] RET  = 5'h02;
  localparam logic [4:0] CALL = 5'h01;

  logic                   clock;
  logic                   sys_rst;
  sam_bus_s               core_bus;
  logic [`SAM_DW-1:0]     rdata;
  sam_ev_s                core_ev;
  logic                   exception;
  logic                   user_jump;
  logic [`SAM_GROUPS-1:0] mmu_user_rights;
  sam_bus_s               periph_bus;
  logic [`SAM_DW-1:0]     periph_rdata;
  logic                   boot_done;
  logic                   test_lock_pin;
  sam_mode_s              mode_status_register;
  sam_sub_e               sub_mode;
  logic                   irq;
  int                     miscompares;
  int                     comparisons;
  int                     cycles;
  logic [7:0]             d;
  logic                   ps;
  logic                   ok;
  logic [3:0]             g;
  logic [15:0]            r;
  logic [7:0]             v;
  logic [7:0]             a;
  logic [7:0]             shadow [0:15];

  sam_ctrl u_sam_ctrl (
    .clock                (clock),
    .sys_rst              (sys_rst),
    .core_bus             (core_bus),
    .rdata                (rdata),
    .core_ev              (core_ev),
    .exception            (exception),
    .user_jump            (user_jump),
    .mmu_user_rights      (mmu_user_rights),
    .periph_bus           (periph_bus),
    .periph_rdata         (periph_rdata),
    .boot_done            (boot_done),
    .test_lock_pin        (test_lock_pin),
    .mode_status_register (mode_status_register),
    .sub_mode             (sub_mode),
    .irq                  (irq)
  );

  sam_periph_model u_sam_periph_model (
    .clock        (clock),
    .periph_bus   (periph_bus),
    .periph_rdata (periph_rdata)
  );

  initial clock = 1'b0;
  always #25 clock = ~clock;

  // ********************************************************
  // Checking and bus tasks
  // ********************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Denied reads must come back as the fixed zero value
  function automatic logic [7:0] exp_read(input logic       ok_in,
                                          input logic [7:0] val);
    return ok_in ? val : `SAM_ZERO_DATA;
  endfunction : exp_read

  task automatic end_sim();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] val);
    @(posedge clock);
    core_bus.wr    <= 1'b1;
    core_bus.addr  <= ad;
    core_bus.wdata <= val;
    #1 ps = periph_bus.wr;
    @(posedge clock);
    core_bus.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] ad);
    @(posedge clock);
    core_bus.rd   <= 1'b1;
    core_bus.addr <= ad;
    #1 ps = periph_bus.rd;
    @(posedge clock);
    core_bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // One event pulse; results are sampled just after the taking edge
  task automatic ev(input logic [4:0] k, input logic [23:0] t);
    @(posedge clock);
    {core_ev.system_vector_call, core_ev.exc_event, core_ev.irq_entry,
     core_ev.return_from_interrupt, core_ev.call_exec} <= k;
    core_ev.call_target <= t;
    @(posedge clock);
    {core_ev.system_vector_call, core_ev.exc_event, core_ev.irq_entry,
     core_ev.return_from_interrupt, core_ev.call_exec} <= 5'h00;
    #1;
  endtask : ev

  task automatic expect_mode(input logic [1:0] m, input logic x);
    check(mode_status_register, m);
    check(exception, x);
  endtask : expect_mode

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    sys_rst = 1'b1;
    core_bus = '0;
    core_ev = '0;
    mmu_user_rights = '0;
    boot_done = 1'b0;
    test_lock_pin = 1'b1;
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    void'($urandom(32'h399f7d40));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    #1 check(mode_status_register, 2'b10);
    check(sub_mode, SUB_BOOT);
    rd_reg(`SAM_A_MSR);
    check(d, 8'h02);
    repeat (4) @(posedge clock);
    boot_done <= 1'b1;
    @(posedge clock);
    boot_done <= 1'b0;
    #1 check(sub_mode, SUB_CL);
    check(mode_status_register, 2'b01);
    wr_reg(`SAM_A_IMSK, 8'h01);
    wr_reg(`SAM_A_CFG, 8'h00);
    wr_reg(`SAM_A_CLR0, 8'h0f);
    rd_reg(`SAM_A_CLR0);
    check(d, 8'h0f);
    wr_reg(`SAM_A_BANK, 8'ha5);
    for (int i = 0; i < 16; i++)
    begin
      shadow[i] = 8'($urandom);
      wr_reg({2'b10, 4'(i), 2'b00}, shadow[i]);
      check(ps, 1'b1);
      rd_reg({2'b10, 4'(i), 2'b00});
      check(ps, 1'b1);
      check(d, shadow[i]);
    end
    ev(CALL, 24'h7fffff);
    check(user_jump, 1'b0);
    expect_mode(2'b01, 1'b0);
    ev(CALL, `SAM_USER_ENTRY);
    check(user_jump, 1'b1);
    expect_mode(2'b00, 1'b0);
    wr_reg(`SAM_A_BANK, 8'h3c);
    rd_reg(`SAM_A_BANK);
    check(d, 8'h3c);
    wr_reg(`SAM_A_MSR, 8'hff);
    rd_reg(`SAM_A_MSR);
    check(d, 8'h00);
    wr_reg(`SAM_A_CFG, 8'h01);
    rd_reg(`SAM_A_CFG);
    check(d, 8'h00);
    check(irq, 1'b1);
    rd_reg(8'h10);
    check(d, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      r = 16'($urandom);
      g = 4'($urandom);
      v = 8'($urandom);
      a = {2'b10, g, 2'b00};
      ok = r[g];
      @(posedge clock);
      mmu_user_rights <= r;
      if ($urandom % 2 == 0)
      begin
        wr_reg(a, v);
        check(ps, ok);
        if (ok)
          shadow[g] = v;
      end
      else
      begin
        rd_reg(a);
        check(ps, ok);
        check(d, exp_read(ok, shadow[g]));
      end
    end
    ev(VCALL, 24'h0);
    expect_mode(2'b01, 1'b0);
    rd_reg(`SAM_A_BANK);
    check(d, 8'ha5);
    ev(VCALL, 24'h0);
    expect_mode(2'b01, 1'b1);
    ev(RET, 24'h0);
    expect_mode(2'b01, 1'b0);
    ev(RET, 24'h0);
    expect_mode(2'b00, 1'b0);
    ev(EXC, 24'h0);
    expect_mode(2'b01, 1'b1);
    ev(RET, 24'h0);
    expect_mode(2'b00, 1'b0);
    ev(IRQE, 24'h0);
    expect_mode(2'b01, 1'b0);
    ev(RET, 24'h0);
    expect_mode(2'b00, 1'b0);
    ev(RET, 24'h0);
    expect_mode(2'b01, 1'b1);
    rd_reg(`SAM_A_IST);
    check(d, 8'h07);
    wr_reg(`SAM_A_IST, 8'h07);
    @(posedge clock);
    #1 check(irq, 1'b0);
    wr_reg(`SAM_A_CFG, 8'h01);
    ev(RET, 24'h0);
    expect_mode(2'b00, 1'b0);
    @(posedge clock);
    core_ev.irq_active <= 1'b1;
    ev(IRQE, 24'h0);
    expect_mode(2'b00, 1'b0);
    ev(RET, 24'h0);
    expect_mode(2'b00, 1'b0);
    @(posedge clock);
    core_ev.irq_active <= 1'b0;
    ev(RET, 24'h0);
    expect_mode(2'b01, 1'b1);
    // Fault bit is set but masked, so the line stays low until unmasked
    @(posedge clock);
    #1 check(irq, 1'b0);
    wr_reg(`SAM_A_IMSK, 8'h02);
    @(posedge clock);
    #1 check(irq, 1'b1);
    // Second start-up with the lock pin low must reach the test sub-mode
    @(posedge clock);
    sys_rst       <= 1'b1;
    test_lock_pin <= 1'b0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    #1 check(mode_status_register, 2'b10);
    check(exception, 1'b0);
    check(rdata, 8'h00);
    check(sub_mode, SUB_BOOT);
    // Pin needs a few cycles through the synchroniser before boot ends
    repeat (4) @(posedge clock);
    boot_done <= 1'b1;
    @(posedge clock);
    boot_done <= 1'b0;
    #1 check(sub_mode, SUB_TEST);
    check(mode_status_register, 2'b10);
    wr_reg(`SAM_A_CLR0, 8'h01);
    test_lock_pin <= 1'b1;
    repeat (6) @(posedge clock);
    #1 check(sub_mode, SUB_CL);
    wr_reg(`SAM_A_CLR0, 8'hff);
    rd_reg(`SAM_A_CLR0);
    check(d, 8'h01);
    wr_reg({2'b10, 4'h0, 2'b00}, 8'h11);
    check(ps, 1'b1);
    wr_reg({2'b10, 4'h1, 2'b00}, 8'h22);
    check(ps, 1'b0);
    end_sim();
  end
endmodule : sfr_access_mode_control_test
